// >>> src/pio_top.sv
// programmable i/o port block with apb register access
// Operation
// - the large package option has 113 usable port lines and the small one 87, the nmi line not counted.
// - each line except the nmi-shared one has its own direction bit, while pull-ups are chosen for groups of four lines.
// - the nmi-shared line is input only, has no pull-up or direction bit, and reads at bit 5 of port 8.
// - a pin assigned to a digital peripheral output is driven whatever its direction bit says.
// - in memory expansion and microprocessor modes direction writes to bus control pins are ignored.
// - an input line reads back its pin level, and a write only updates the latch.
// - an output line reads back its latch, and a write goes to the latch and onto the pin.
// - a pull-up is connected only when its group bit is set and the line is an input.
// - in bus modes pull-ups on ports 0 to 3, port 4 lines 0 to 3 and port 5 are off, bits still writable.
// - with the latch readback select bit set, port 1 reads return its latch regardless of direction.
// - an enabled dac channel output removes the pull-up of the line carrying it.
module pio_top
  import pio_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pio_pkg::PIO_ADDR_W-1:0] paddr,
  input wire logic [pio_pkg::PIO_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [pio_pkg::PIO_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic large_package,
  input wire logic [1:0] proc_mode,
  input wire logic [pio_pkg::PIO_NUM_LINES-1:0] bus_ctrl_pins,
  input wire logic [pio_pkg::PIO_NUM_LINES-1:0] periph_out_en,
  input wire logic [pio_pkg::PIO_NUM_LINES-1:0] periph_out_val,
  input wire logic [1:0] dac_channel_output_enable,
  input wire logic [pio_pkg::PIO_NUM_LINES-1:0] pin_in,
  output logic [pio_pkg::PIO_NUM_LINES-1:0] pin_out,
  output logic [pio_pkg::PIO_NUM_LINES-1:0] pin_oe_n,
  output logic [pio_pkg::PIO_NUM_LINES-1:0] pullup_en
);
  logic [PIO_DATA_W-1:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [7:0] pullup_ctrl_reg_a;
  logic [7:0] pullup_ctrl_reg_b;
  logic [7:0] pullup_ctrl_reg_c;
  logic [5:0] pullup_ctrl_reg_d;
  logic latch_readback_sel;
  logic [PIO_NUM_LINES-1:0] line_exists;
  logic [PIO_NUM_LINES-1:0] dir_impl;
  logic [PIO_NUM_LINES-1:0] pu_capable;
  logic [PIO_NUM_LINES-1:0] bus_area;
  logic [PIO_NUM_LINES-1:0] dir_lock;
  logic [PIO_NUM_LINES-1:0] dir_all;
  logic [PIO_NUM_GROUPS-1:0] group_en;
  logic [7:0] port_rdata [PIO_NUM_PORTS];
  logic bus_mode;
  logic setup;
  logic access;
  logic do_write;
  logic [1:0] bank;
  logic [3:0] port_idx;
  logic port_valid;
  logic [7:0] wbyte;
  logic addr_ok;
  logic [PIO_DATA_W-1:0] rd_nxt;
  logic mode_mem_exp;
  logic mode_micro;
  logic aligned;
  logic misc_ok;
  logic byte_en;
  logic sel_pu_a;
  logic sel_pu_b;
  logic sel_pu_c;
  logic sel_pu_d;
  logic sel_ctrl;
  logic sel_mode;
  logic wr_pu_a;
  logic wr_pu_b;
  logic wr_pu_c;
  logic wr_pu_d;
  logic wr_ctrl;
  logic [PIO_NUM_PORTS-1:0] wr_data_sel;
  logic [PIO_NUM_PORTS-1:0] wr_dir_sel;
  logic [7:0] rd_data_byte;
  logic [7:0] rd_dir_byte;
  logic [7:0] rd_misc_byte;
  logic [7:0] port_dir [PIO_NUM_PORTS];
  logic [2:0] mode_status;

  // bus control pins keep their function only when the external bus is on
  assign mode_mem_exp = (proc_mode == PIO_MODE_MEM_EXP);
  assign mode_micro = (proc_mode == PIO_MODE_MICRO);
  assign bus_mode = mode_mem_exp || mode_micro;

  // ---------------------------------------------------------------- line map
  // package option decides which lines exist; the small one stops after port 10
  always_comb begin
    for (int l = 0; l < PIO_NUM_LINES; l++) begin
      if (l / PIO_PORT_W < PIO_SMALL_PORTS) begin
        line_exists[l] = 1'b1;
      end else if (l / PIO_PORT_W < PIO_LARGE_FULL_PORTS) begin
        line_exists[l] = large_package;
      end else begin
        line_exists[l] = large_package && (l % PIO_PORT_W < PIO_LAST_PORT_LINES);
      end
    end
  end

  // the nmi line has no direction bit and no pull-up; two port 7 lines lack a pull-up as well
  always_comb begin
    for (int l = 0; l < PIO_NUM_LINES; l++) begin
      dir_impl[l] = line_exists[l] && (l != PIO_NMI_LINE);
      pu_capable[l] = dir_impl[l] && (l != PIO_NO_PU_LO) && (l != PIO_NO_PU_HI);
    end
  end

  // lines that the external bus borrows in bus modes; their pull-ups are forced off
  always_comb begin
    for (int l = 0; l < PIO_NUM_LINES; l++) begin
      bus_area[l] = (l <= PIO_BUS_PU_A_HI) || (l >= PIO_BUS_PU_B_LO && l <= PIO_BUS_PU_B_HI);
    end
  end

  // a locked bit keeps its value, so software cannot turn a bus control pin around
  assign dir_lock = bus_mode ? bus_ctrl_pins : '0;

  // ---------------------------------------------------------------- apb decode
  // only the lowest byte lane carries register data
  assign byte_en = pstrb[0];
  assign setup = psel && !penable;
  assign access = psel && penable && pready_r;
  assign do_write = access && pwrite && byte_en && addr_ok;
  assign bank = paddr[7:6];
  assign port_idx = paddr[5:2];
  assign port_valid = (32'(port_idx) < PIO_NUM_PORTS);
  assign wbyte = pwdata[7:0];

  assign aligned = (paddr[1:0] == 2'h0);
  assign sel_pu_a = (paddr == PIO_PULLUP_A_ADDR);
  assign sel_pu_b = (paddr == PIO_PULLUP_B_ADDR);
  assign sel_pu_c = (paddr == PIO_PULLUP_C_ADDR);
  assign sel_pu_d = (paddr == PIO_PULLUP_D_ADDR);
  assign sel_ctrl = (paddr == PIO_PORT_CTRL_ADDR);
  assign sel_mode = (paddr == PIO_MODE_STAT_ADDR);
  assign misc_ok = sel_pu_a || sel_pu_b || sel_pu_c || sel_pu_d || sel_ctrl || sel_mode;
  assign mode_status = {large_package, proc_mode};

  // one strobe per register, so a write can never reach two of them
  assign wr_pu_a = do_write && sel_pu_a;
  assign wr_pu_b = do_write && sel_pu_b;
  assign wr_pu_c = do_write && sel_pu_c;
  assign wr_pu_d = do_write && sel_pu_d;
  assign wr_ctrl = do_write && sel_ctrl;

  // per-port strobes; an index past the last port selects nothing
  always_comb begin
    for (int p = 0; p < PIO_NUM_PORTS; p++) begin
      wr_data_sel[p] = do_write && (bank == PIO_BANK_DATA) && (32'(port_idx) == p);
      wr_dir_sel[p] = do_write && (bank == PIO_BANK_DIR) && (32'(port_idx) == p);
    end
  end

  // direction bytes by port for the read path
  always_comb begin
    for (int p = 0; p < PIO_NUM_PORTS; p++) begin
      port_dir[p] = dir_all[p*PIO_PORT_W +: PIO_PORT_W];
    end
  end

  // misaligned or unmapped offsets answer with an error and change nothing
  always_comb begin
    addr_ok = 1'b0;
    if (aligned) begin
      unique case (bank)
        PIO_BANK_DATA: addr_ok = port_valid;
        PIO_BANK_DIR: addr_ok = port_valid;
        PIO_BANK_MISC: addr_ok = misc_ok;
        default: addr_ok = 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------- ports
  genvar gp;
  generate
    for (gp = 0; gp < PIO_NUM_PORTS; gp++) begin : g_port
      pio_port u_port (
        .clock(clock),
        .reset(reset),
        .wr_data(wr_data_sel[gp]),
        .wr_dir(wr_dir_sel[gp]),
        .wdata(wbyte),
        .dir_impl(dir_impl[gp*PIO_PORT_W +: PIO_PORT_W]),
        .dir_lock(dir_lock[gp*PIO_PORT_W +: PIO_PORT_W]),
        .line_exists(line_exists[gp*PIO_PORT_W +: PIO_PORT_W]),
        .latch_readback((gp == PIO_RB_PORT) && latch_readback_sel),
        .periph_oe(periph_out_en[gp*PIO_PORT_W +: PIO_PORT_W]),
        .periph_val(periph_out_val[gp*PIO_PORT_W +: PIO_PORT_W]),
        .pin_in(pin_in[gp*PIO_PORT_W +: PIO_PORT_W]),
        .rdata(port_rdata[gp]),
        .dir(dir_all[gp*PIO_PORT_W +: PIO_PORT_W]),
        .pin_out_r(pin_out[gp*PIO_PORT_W +: PIO_PORT_W]),
        .pin_oe_n_r(pin_oe_n[gp*PIO_PORT_W +: PIO_PORT_W])
      );
    end
  endgenerate

  // ---------------------------------------------------------------- pull-ups
  // registers stay writable in bus modes; the masking happens downstream
  always_ff @(posedge clock) begin
    if (reset) begin
      pullup_ctrl_reg_a <= PIO_RESET_BYTE;
    end else if (wr_pu_a) begin
      pullup_ctrl_reg_a <= wbyte;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pullup_ctrl_reg_b <= PIO_RESET_BYTE;
    end else if (wr_pu_b) begin
      pullup_ctrl_reg_b <= wbyte;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pullup_ctrl_reg_c <= PIO_RESET_BYTE;
    end else if (wr_pu_c) begin
      pullup_ctrl_reg_c <= wbyte;
    end
  end

  // only six groups exist above port 11, so the top two bits are not stored
  always_ff @(posedge clock) begin
    if (reset) begin
      pullup_ctrl_reg_d <= PIO_RESET_PU_D;
    end else if (wr_pu_d) begin
      pullup_ctrl_reg_d <= wbyte[PIO_PU_D_GROUPS-1:0];
    end
  end

  assign group_en = {pullup_ctrl_reg_d, pullup_ctrl_reg_c, pullup_ctrl_reg_b, pullup_ctrl_reg_a};

  pio_pullup u_pullup (
    .clock(clock),
    .reset(reset),
    .group_en(group_en),
    .dir(dir_all),
    .pu_capable(pu_capable),
    .bus_area(bus_area),
    .bus_mode(bus_mode),
    .dac_oe(dac_channel_output_enable),
    .pullup_en_r(pullup_en)
  );

  // ---------------------------------------------------------------- port control
  always_ff @(posedge clock) begin
    if (reset) begin
      latch_readback_sel <= 1'b0;
    end else if (wr_ctrl) begin
      latch_readback_sel <= wbyte[0];
    end
  end

  // ---------------------------------------------------------------- read data
  // pins are read at the setup edge, so the value is one cycle older than pready
  always_comb begin
    rd_data_byte = '0;
    if (port_valid) begin
      rd_data_byte = port_rdata[port_idx];
    end
  end

  always_comb begin
    rd_dir_byte = '0;
    if (port_valid) begin
      rd_dir_byte = port_dir[port_idx];
    end
  end

  // unused bits read as zero so software can compare whole words
  always_comb begin
    rd_misc_byte = '0;
    if (sel_pu_a) begin
      rd_misc_byte = pullup_ctrl_reg_a;
    end else if (sel_pu_b) begin
      rd_misc_byte = pullup_ctrl_reg_b;
    end else if (sel_pu_c) begin
      rd_misc_byte = pullup_ctrl_reg_c;
    end else if (sel_pu_d) begin
      rd_misc_byte[PIO_PU_D_GROUPS-1:0] = pullup_ctrl_reg_d;
    end else if (sel_ctrl) begin
      rd_misc_byte[0] = latch_readback_sel;
    end else if (sel_mode) begin
      rd_misc_byte[2:0] = mode_status;
    end
  end

  always_comb begin
    rd_nxt = '0;
    unique case (bank)
      PIO_BANK_DATA: rd_nxt[7:0] = rd_data_byte;
      PIO_BANK_DIR: rd_nxt[7:0] = rd_dir_byte;
      PIO_BANK_MISC: rd_nxt[7:0] = rd_misc_byte;
      default: rd_nxt = '0;
    endcase
  end

  // ---------------------------------------------------------------- apb answer
  // one wait-free access phase: pready rises in the first access cycle
  always_ff @(posedge clock) begin
    if (reset) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= setup;
    end
  end

  // the error flag stands with pready and for exactly as long
  always_ff @(posedge clock) begin
    if (reset) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= setup && !addr_ok;
    end
  end

  // read data stands only with pready; zero at other times keeps old words off the bus
  always_ff @(posedge clock) begin
    if (reset) begin
      prdata_r <= '0;
    end else if (setup && !pwrite && addr_ok) begin
      prdata_r <= rd_nxt;
    end else begin
      prdata_r <= '0;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
endmodule

// >>> src/pio_pkg.sv
// constants shared by the programmable i/o port block
package pio_pkg;
  localparam int PIO_NUM_PORTS = 15;
  localparam int PIO_PORT_W = 8;
  localparam int PIO_NUM_LINES = PIO_NUM_PORTS * PIO_PORT_W;
  localparam int PIO_NUM_GROUPS = PIO_NUM_LINES / 4;
  localparam int PIO_GROUP_W = 4;
  // usable line counts per package option (input-only nmi line excluded)
  localparam int PIO_LINES_SMALL = 87;
  localparam int PIO_LINES_LARGE = 113;
  localparam int PIO_SMALL_PORTS = 11;
  localparam int PIO_LARGE_FULL_PORTS = 14;
  localparam int PIO_LAST_PORT_LINES = 2;
  localparam int PIO_NMI_LINE = 69;
  localparam int PIO_NMI_PORT = 8;
  localparam int PIO_NMI_BIT = 5;
  localparam int PIO_RB_PORT = 1;
  localparam int PIO_DAC0_LINE = 75;
  localparam int PIO_DAC1_LINE = 76;
  localparam int PIO_NO_PU_LO = 56;
  localparam int PIO_NO_PU_HI = 57;
  localparam int PIO_BUS_PU_A_HI = 35;
  localparam int PIO_BUS_PU_B_LO = 40;
  localparam int PIO_BUS_PU_B_HI = 47;
  localparam int PIO_ADDR_W = 8;
  localparam int PIO_DATA_W = 32;
  localparam int PIO_PU_REG_GROUPS = 8;
  localparam int PIO_PU_D_GROUPS = 6;
  // processor mode codes
  localparam logic [1:0] PIO_MODE_SINGLE = 2'h0;
  localparam logic [1:0] PIO_MODE_MEM_EXP = 2'h1;
  localparam logic [1:0] PIO_MODE_MICRO = 2'h3;
  // register map: bank in addr[7:6], port index in addr[5:2]
  localparam logic [1:0] PIO_BANK_DATA = 2'h0;
  localparam logic [1:0] PIO_BANK_DIR = 2'h1;
  localparam logic [1:0] PIO_BANK_MISC = 2'h2;
  localparam logic [7:0] PIO_PULLUP_A_ADDR = 8'h80;
  localparam logic [7:0] PIO_PULLUP_B_ADDR = 8'h84;
  localparam logic [7:0] PIO_PULLUP_C_ADDR = 8'h88;
  localparam logic [7:0] PIO_PULLUP_D_ADDR = 8'h8C;
  localparam logic [7:0] PIO_PORT_CTRL_ADDR = 8'h90;
  localparam logic [7:0] PIO_MODE_STAT_ADDR = 8'h94;
  localparam logic [7:0] PIO_RESET_BYTE = 8'h00;
  localparam logic [5:0] PIO_RESET_PU_D = 6'h00;
endpackage

// >>> src/pio_port.sv
// one eight-line port: output latch, direction bits, pin drive and data readback
module pio_port
  import pio_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic wr_data,
  input wire logic wr_dir,
  input wire logic [7:0] wdata,
  input wire logic [7:0] dir_impl,
  input wire logic [7:0] dir_lock,
  input wire logic [7:0] line_exists,
  input wire logic latch_readback,
  input wire logic [7:0] periph_oe,
  input wire logic [7:0] periph_val,
  input wire logic [7:0] pin_in,
  output logic [7:0] rdata,
  output logic [7:0] dir,
  output logic [7:0] pin_out_r,
  output logic [7:0] pin_oe_n_r
);
  logic [7:0] latch_r;
  logic [7:0] dir_r;

  // a write always lands in the latch, whatever the direction
  always_ff @(posedge clock) begin
    if (reset) begin
      latch_r <= PIO_RESET_BYTE;
    end else if (wr_data) begin
      latch_r <= wdata;
    end
  end

  // locked bits (bus control pins) keep their value; missing bits stay input
  always_ff @(posedge clock) begin
    if (reset) begin
      dir_r <= PIO_RESET_BYTE;
    end else if (wr_dir) begin
      dir_r <= ((wdata & ~dir_lock) | (dir_r & dir_lock)) & dir_impl;
    end
  end

  assign dir = dir_r;

  always_comb begin
    for (int b = 0; b < PIO_PORT_W; b++) begin
      if (!line_exists[b]) begin
        rdata[b] = 1'b0;
      end else if (dir_r[b] || latch_readback) begin
        rdata[b] = latch_r[b];
      end else begin
        rdata[b] = pin_in[b];
      end
    end
  end

  // peripheral outputs take the pin whatever the direction bit says
  always_ff @(posedge clock) begin
    if (reset) begin
      pin_out_r <= PIO_RESET_BYTE;
      pin_oe_n_r <= ~PIO_RESET_BYTE;
    end else begin
      pin_out_r <= (periph_oe & periph_val) | (~periph_oe & latch_r);
      pin_oe_n_r <= ~(line_exists & (periph_oe | dir_r));
    end
  end
endmodule

// >>> src/pio_pullup.sv
// pull-up enables for every line, from the four-line group bits
module pio_pullup
  import pio_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [pio_pkg::PIO_NUM_GROUPS-1:0] group_en,
  input wire logic [pio_pkg::PIO_NUM_LINES-1:0] dir,
  input wire logic [pio_pkg::PIO_NUM_LINES-1:0] pu_capable,
  input wire logic [pio_pkg::PIO_NUM_LINES-1:0] bus_area,
  input wire logic bus_mode,
  input wire logic [1:0] dac_oe,
  output logic [pio_pkg::PIO_NUM_LINES-1:0] pullup_en_r
);
  logic [PIO_NUM_LINES-1:0] pu_nxt;

  always_comb begin
    for (int l = 0; l < PIO_NUM_LINES; l++) begin
      // pull-up only on an input line whose group bit is set
      pu_nxt[l] = group_en[l / PIO_GROUP_W] & ~dir[l] & pu_capable[l];
      if (bus_mode && bus_area[l]) begin
        pu_nxt[l] = 1'b0;
      end
    end
    // an enabled analog output must not be loaded by the resistor
    if (dac_oe[0]) begin
      pu_nxt[PIO_DAC0_LINE] = 1'b0;
    end
    if (dac_oe[1]) begin
      pu_nxt[PIO_DAC1_LINE] = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pullup_en_r <= '0;
    end else begin
      pullup_en_r <= pu_nxt;
    end
  end
endmodule

// >>> verification/pio_pins_model.sv
// external pin model: outside drivers, pull-ups and floating lines
module pio_pins_model
  import pio_pkg::*;
(
  input wire logic clock,
  input wire logic [pio_pkg::PIO_NUM_LINES-1:0] pin_out,
  input wire logic [pio_pkg::PIO_NUM_LINES-1:0] pin_oe_n,
  input wire logic [pio_pkg::PIO_NUM_LINES-1:0] pullup_en,
  input wire logic [pio_pkg::PIO_NUM_LINES-1:0] ext_en,
  input wire logic [pio_pkg::PIO_NUM_LINES-1:0] ext_val,
  output logic [pio_pkg::PIO_NUM_LINES-1:0] pin_in
);
  logic float_r = 1'b0;
  // an undriven line without pull-up toggles, so a stale level cannot pass for a read
  always @(posedge clock) begin
    float_r <= ~float_r;
  end
  always_comb begin
    for (int i = 0; i < PIO_NUM_LINES; i++) begin
      pin_in[i] = !pin_oe_n[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : pullup_en[i] ? 1'b1 : float_r;
    end
  end
endmodule

// >>> verification/pio_top_chk.sv
// assertion checker for the programmable i/o port block
module pio_top_chk
  import pio_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pio_pkg::PIO_ADDR_W-1:0] paddr,
  input wire logic [pio_pkg::PIO_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [pio_pkg::PIO_DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic large_package,
  input wire logic [1:0] proc_mode,
  input wire logic [pio_pkg::PIO_NUM_LINES-1:0] bus_ctrl_pins,
  input wire logic [pio_pkg::PIO_NUM_LINES-1:0] periph_out_en,
  input wire logic [pio_pkg::PIO_NUM_LINES-1:0] periph_out_val,
  input wire logic [1:0] dac_channel_output_enable,
  input wire logic [pio_pkg::PIO_NUM_LINES-1:0] pin_in,
  input wire logic [pio_pkg::PIO_NUM_LINES-1:0] pin_out,
  input wire logic [pio_pkg::PIO_NUM_LINES-1:0] pin_oe_n,
  input wire logic [pio_pkg::PIO_NUM_LINES-1:0] pullup_en
);
  logic rst_r;
  logic [87:0] pe_r;
  logic [87:0] pv_r;
  // pin outputs are registered, so compare them with the inputs of the edge before
  always_ff @(posedge clock) begin
    rst_r <= reset;
    pe_r <= periph_out_en[87:0];
    pv_r <= periph_out_val[87:0];
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence answer_s;
    pready ##1 !pready;
  endsequence
  AST_READY_ONE: assert property (setup_s |=> answer_s)
    else $error("pready not a single pulse after setup");
  AST_READY_CAUSE: assert property (!(psel && !penable) |=> !pready)
    else $error("pready without setup");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == '0)
    else $error("read data outside access");
  AST_ERR_QUIET: assert property (pslverr |-> pready && prdata == '0)
    else $error("error response malformed");
  AST_RESET_SAFE: assert property (disable iff (1'b0) reset |=> &pin_oe_n && pullup_en == '0)
    else $error("outputs not safe after reset");
  AST_NMI_NO_PU: assert property (!pullup_en[PIO_NMI_LINE])
    else $error("pull-up on nmi line");
  AST_PERIPH_DRIVE: assert property (!rst_r |-> (pin_oe_n[87:0] & pe_r) == '0
      && ((pin_out[87:0] ^ pv_r) & pe_r) == '0) else $error("peripheral output not driven");
  AST_PU_INPUT: assert property (!rst_r |-> (pullup_en[87:0] & ~pin_oe_n[87:0] & ~pe_r) == '0)
    else $error("pull-up on output line");
  AST_BUS_PU_OFF: assert property ($past(proc_mode[0]) && !rst_r |-> pullup_en[35:0] == '0
      && pullup_en[47:40] == '0) else $error("pull-up in bus mode");
  AST_DAC_PU_OFF: assert property ($past(dac_channel_output_enable[0]) && !rst_r |-> !pullup_en[75])
    else $error("pull-up on enabled dac line");
endmodule

bind pio_top pio_top_chk pio_top_chk_i (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .large_package(large_package), .proc_mode(proc_mode), .bus_ctrl_pins(bus_ctrl_pins),
  .periph_out_en(periph_out_en), .periph_out_val(periph_out_val),
  .dac_channel_output_enable(dac_channel_output_enable), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe_n(pin_oe_n), .pullup_en(pullup_en));

// >>> verification/tb_pio_top.sv
// self-checking bench for the programmable i/o port block
module tb_pio_top
  import pio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, reset, psel, penable, pwrite, large_package, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [1:0] proc_mode, dac;
  logic [PIO_NUM_LINES-1:0] bus_ctrl, pe, pv, pin_in, pin_out, pin_oe_n, pullup_en, ext_en, ext_val;
  logic [1:0] modes [2] = '{PIO_MODE_MEM_EXP, PIO_MODE_MICRO};
  int err_total, tests_run;
  pio_top pio_top_i (.clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .large_package(large_package), .proc_mode(proc_mode), .bus_ctrl_pins(bus_ctrl), .periph_out_en(pe),
    .periph_out_val(pv), .dac_channel_output_enable(dac), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pullup_en(pullup_en));
  pio_pins_model pio_pins_model_i (.clock(clock), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pullup_en(pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (err_total == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // one transfer; an idle edge follows so the next request never lands in the same time step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [32:0] q);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    // the wait ends when pready is seen high; only the watchdog ends it if pready never comes
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    q = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [32:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [7:0] a, input logic [32:0] exp);
    logic [32:0] q;
    apb(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask
  task automatic wt();
    repeat (3) @(posedge clock);
  endtask
  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, proc_mode, dac} = '0;
    {bus_ctrl, pe, pv, ext_en, ext_val} = '0;
    pstrb = 4'hF;
    large_package = 1'b1;
    err_total = 0;
    tests_run = 0;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    chk({&pin_oe_n, |pullup_en}, 2'b10);
    rc(8'h48, 33'h0);
    ext_en[23:16] <= 8'hFF;
    ext_val[23:16] <= 8'hA5;
    wr(8'h08, 8'h3C);
    rc(8'h08, 33'hA5);
    chk(pin_oe_n[23:16], 8'hFF);
    wr(8'h48, 8'hFF);
    rc(8'h08, 33'h3C);
    chk({pin_oe_n[23:16], pin_out[23:16]}, 16'h003C);
    ext_en[23:16] <= 8'h00;
    wr(8'h48, 8'h0F);
    wr(PIO_PULLUP_A_ADDR, 8'h30);
    wt();
    chk(pullup_en[23:16], 8'hF0);
    rc(8'h08, 33'hFC);
    bus_ctrl[23:16] <= 8'hFF;
    foreach (modes[i]) begin
      proc_mode <= modes[i];
      wr(8'h48, 8'h00);
      rc(8'h48, 33'h0F);
      chk(pullup_en[23:16], 8'h00);
      rc(PIO_PULLUP_A_ADDR, 33'h30);
    end
    proc_mode <= PIO_MODE_SINGLE;
    wr(8'h48, 8'h00);
    rc(8'h48, 33'h00);
    pstrb <= 4'hE;
    wr(8'h48, 8'hFF);
    pstrb <= 4'hF;
    rc(8'h48, 33'h00);
    ext_en[15:8] <= 8'hFF;
    ext_val[15:8] <= 8'hC3;
    wr(8'h04, 8'h5A);
    rc(8'h04, 33'hC3);
    wr(PIO_PORT_CTRL_ADDR, 8'h01);
    rc(8'h04, 33'h5A);
    wr(PIO_PORT_CTRL_ADDR, 8'h00);
    ext_en[69] <= 1'b1;
    ext_val[69] <= 1'b1;
    wr(8'h60, 8'hFF);
    rc(8'h60, 33'hDF);
    rc(8'h20, 33'h20);
    // port 9 direction stays at input while the dac drives its pins
    wr(PIO_PULLUP_C_ADDR, 8'h0C);
    wt();
    chk(pullup_en[79:72], 8'hFF);
    dac <= 2'b01;
    wt();
    chk(pullup_en[79:72], 8'hF7);
    dac <= 2'b10;
    wt();
    chk(pullup_en[79:72], 8'hEF);
    rc(8'h64, 33'h00);
    pe[10] <= 1'b1;
    pv[10] <= 1'b1;
    wt();
    chk({pin_oe_n[10], pin_out[10]}, 2'b01);
    rc(8'h44, 33'h00);
    rc(8'hFC, 33'h100000000);
    wr(8'h78, 8'hFF);
    rc(8'h78, 33'h03);
    large_package <= 1'b0;
    wr(8'h6C, 8'hFF);
    rc(8'h6C, 33'h00);
    summarize();
  end
  initial begin
    repeat (5000) @(posedge clock);
    err_total++;
    summarize();
  end
endmodule
